// ---- core/dpio_pkg.sv ----
// shared constants for the dual parallel port block
package dpio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned P0_W = 8;
  localparam int unsigned P1_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets in the special function space
  localparam logic [ADDR_W-1:0] OFS_PORT0_OUTPUT_LATCH = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT1_OUTPUT_LATCH = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_PORT1_DIRECTION = 6'h09;
  localparam logic [ADDR_W-1:0] OFS_PORT0_DRIVE_TYPE = 6'h0b;
  localparam logic [ADDR_W-1:0] OFS_PORT0_PIN_READ = 6'h0c;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [P0_W-1:0] RST_PORT0_OUTPUT_LATCH = 8'hff;
  localparam logic [P0_W-1:0] RST_PORT0_DRIVE_TYPE = 8'h00;
  localparam logic [P1_W-1:0] RST_PORT1_OUTPUT_LATCH = 7'h00;
  localparam logic [P1_W-1:0] RST_PORT1_DIRECTION = 7'h00;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and codes
  localparam int unsigned P1_IRQ0_BIT = 0;
  localparam int unsigned P1_IRQ1_BIT = 1;
  localparam logic DRIVE_OPEN_DRAIN = 1'b0;
  localparam logic DRIVE_PUSH_PULL = 1'b1;
  localparam logic EDGE_RISING = 1'b0;
  localparam logic EDGE_FALLING = 1'b1;

endpackage : dpio_pkg

// ---- core/dpio_drive.sv ----
// per-bit open-drain or push-pull driver for the eight-bit port
`timescale 1ns/100ps
`default_nettype none
module dpio_drive (
  // settings
  input wire logic [dpio_pkg::P0_W-1:0] latch,
  input wire logic [dpio_pkg::P0_W-1:0] drive_type,
  // pin
  output logic [dpio_pkg::P0_W-1:0] pin_out,
  output logic [dpio_pkg::P0_W-1:0] pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // one driver per bit
  genvar gi;
  generate
    for (gi = 0; gi < dpio_pkg::P0_W; gi = gi + 1) begin : g_bit
      // push-pull drives the latch, open-drain only sinks a zero
      always_comb begin
        if (drive_type[gi] == dpio_pkg::DRIVE_PUSH_PULL) begin // see [RQ5]
          pin_out[gi] = latch[gi];
          pin_oe[gi] = 1'b1;
        end else begin
          pin_out[gi] = 1'b0;
          pin_oe[gi] = ~latch[gi]; // see [RQ16]
        end
      end
    end
  endgenerate

endmodule : dpio_drive
`default_nettype wire

// ---- core/dpio_edge.sv ----
// edge detector feeding one external interrupt request
`timescale 1ns/100ps
`default_nettype none
module dpio_edge (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic enable,
  input wire logic fall_sel,
  // pin level and event
  input wire logic level,
  output logic event_pulse
);

  logic prev_reg;
  logic armed_reg;
  logic event_next;

  ////////////////////////////////////////////////////////////////////////////
  // previous level; first cycle after reset only loads it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg <= level;
      armed_reg <= 1'b1;
    end
  end

  // chosen edge while enabled
  always_comb begin
    if (fall_sel == dpio_pkg::EDGE_FALLING) begin
      event_next = enable && armed_reg && prev_reg && !level;
    end else begin
      event_next = enable && armed_reg && !prev_reg && level;
    end
  end

  // registered one-cycle request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= event_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_edge_seen;
    @(posedge clk) disable iff (!arst_n)
    (enable && armed_reg && (fall_sel == dpio_pkg::EDGE_FALLING) && prev_reg && !level)
    |=> event_pulse;
  endproperty
  a_edge_seen: assert property (p_edge_seen) else $error("selected edge gave no request"); // see [RQ11]

  property p_edge_quiet;
    @(posedge clk) disable iff (!arst_n)
    (!enable || (prev_reg == level)) |=> !event_pulse;
  endproperty
  a_edge_quiet: assert property (p_edge_quiet) else $error("request without an edge"); // see [RQ11]

endmodule : dpio_edge
`default_nettype wire

// ---- core/dpio_ports.sv ----
// register file and pin logic of the two parallel ports
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Operation
// [RQ1] written values held in latch, pins unlatched
// [RQ2] pins sampled in first state of read
// [RQ3] latch and pins update in second state
// [RQ4] reset: port0 latch ones, drive type zero
// [RQ5] drive bit 0 open-drain, 1 push-pull
// [RQ6] software sets latch one before input use
// [RQ7] latch register reads latch, pin register pins
// [RQ8] reset: port1 all inputs; direction 1 outputs
// [RQ9] reset: port1 latch cleared to zero
// [RQ10] software keeps function inputs as inputs
// [RQ11] bit1 pin always feeds its interrupt
// [RQ12] bit0 port or interrupt by select bit
// [RQ13] software avoids read-modify-write on write-only
// [RQ14] software avoids reserved function space addresses
// [RQ15] select 1 means interrupt, pin stays input
// [RQ16] open-drain sinks only a zero latch
module dpio_ports (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register access from the core
  input wire logic [dpio_pkg::ADDR_W-1:0] sfr_addr,
  input wire logic [dpio_pkg::DATA_W-1:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic sfr_state2,
  output logic [dpio_pkg::DATA_W-1:0] sfr_rdata,
  // interrupt pin configuration
  input wire logic irq0_pin_select,
  input wire logic irq1_fall_sel,
  // interrupt requests
  output logic irq0_event,
  output logic irq1_event,
  // eight-bit port pins
  input wire logic [dpio_pkg::P0_W-1:0] port0_pin_in,
  output logic [dpio_pkg::P0_W-1:0] port0_pin_out,
  output logic [dpio_pkg::P0_W-1:0] port0_pin_oe,
  // seven-bit port pins
  input wire logic [dpio_pkg::P1_W-1:0] port1_pin_in,
  output logic [dpio_pkg::P1_W-1:0] port1_pin_out,
  output logic [dpio_pkg::P1_W-1:0] port1_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and strobes
  logic [dpio_pkg::P0_W-1:0] port0_output_latch_reg;
  logic [dpio_pkg::P0_W-1:0] port0_drive_type_reg;
  logic [dpio_pkg::P1_W-1:0] port1_output_latch_reg;
  logic [dpio_pkg::P1_W-1:0] port1_direction_reg;
  logic [dpio_pkg::DATA_W-1:0] rdata_next;
  logic wr_take;
  logic rd_take;
  logic sel_p0_latch;
  logic sel_p1_latch;
  logic sel_p1_dir;
  logic sel_p0_drive;
  logic sel_p0_pin;
  logic irq0_level;
  logic first_cyc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign sel_p0_latch = (sfr_addr == dpio_pkg::OFS_PORT0_OUTPUT_LATCH);
  assign sel_p1_latch = (sfr_addr == dpio_pkg::OFS_PORT1_OUTPUT_LATCH);
  assign sel_p1_dir = (sfr_addr == dpio_pkg::OFS_PORT1_DIRECTION);
  assign sel_p0_drive = (sfr_addr == dpio_pkg::OFS_PORT0_DRIVE_TYPE);
  assign sel_p0_pin = (sfr_addr == dpio_pkg::OFS_PORT0_PIN_READ);

  // writes land in the second state, reads sample in the first
  assign wr_take = sfr_wr && sfr_state2; // see [RQ3]
  assign rd_take = sfr_rd && !sfr_state2; // see [RQ2]

  ////////////////////////////////////////////////////////////////////////////
  // eight-bit port output latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port0_output_latch_reg <= dpio_pkg::RST_PORT0_OUTPUT_LATCH; // see [RQ4]
    end else if (wr_take && sel_p0_latch) begin
      port0_output_latch_reg <= sfr_wdata; // see [RQ1]
    end
  end

  // eight-bit port drive type
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port0_drive_type_reg <= dpio_pkg::RST_PORT0_DRIVE_TYPE; // see [RQ4]
    end else if (wr_take && sel_p0_drive) begin
      port0_drive_type_reg <= sfr_wdata;
    end
  end

  // seven-bit port output latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port1_output_latch_reg <= dpio_pkg::RST_PORT1_OUTPUT_LATCH; // see [RQ9]
    end else if (wr_take && sel_p1_latch) begin
      port1_output_latch_reg <= sfr_wdata[dpio_pkg::P1_W-1:0]; // see [RQ1]
    end
  end

  // seven-bit port direction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port1_direction_reg <= dpio_pkg::RST_PORT1_DIRECTION; // see [RQ8]
    end else if (wr_take && sel_p1_dir) begin
      port1_direction_reg <= sfr_wdata[dpio_pkg::P1_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; pin register shows the live pins, not the latch
  always_comb begin
    rdata_next = dpio_pkg::READ_UNMAPPED;
    unique case (1'b1)
      sel_p0_latch: rdata_next = port0_output_latch_reg; // see [RQ7]
      sel_p1_latch: rdata_next = {1'b0, port1_output_latch_reg};
      sel_p1_dir: rdata_next = {1'b0, port1_direction_reg};
      sel_p0_drive: rdata_next = port0_drive_type_reg;
      sel_p0_pin: rdata_next = port0_pin_in; // see [RQ7]
      default: rdata_next = dpio_pkg::READ_UNMAPPED;
    endcase
  end

  // read data captured at the first-state edge and then held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= dpio_pkg::READ_UNMAPPED;
    end else if (rd_take) begin
      sfr_rdata <= rdata_next; // see [RQ2]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // eight-bit port drivers
  dpio_drive u_drive (
    .latch(port0_output_latch_reg),
    .drive_type(port0_drive_type_reg),
    .pin_out(port0_pin_out),
    .pin_oe(port0_pin_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // seven-bit port drivers; bit 0 forced to input while it serves irq0
  always_comb begin
    port1_pin_out = port1_output_latch_reg;
    port1_pin_oe = port1_direction_reg; // see [RQ8]
    if (irq0_pin_select) begin
      port1_pin_oe[dpio_pkg::P1_IRQ0_BIT] = 1'b0; // see [RQ15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin feeds; irq0 idles high when the pin is a port
  assign irq0_level = irq0_pin_select ? port1_pin_in[dpio_pkg::P1_IRQ0_BIT] : 1'b1; // see [RQ12]

  // irq0 falls only, and only when selected
  dpio_edge u_irq0 (
    .clk(clk),
    .arst_n(arst_n),
    .enable(irq0_pin_select), // see [RQ15]
    .fall_sel(dpio_pkg::EDGE_FALLING),
    .level(irq0_level),
    .event_pulse(irq0_event)
  );

  // irq1 watches its pin even when the pin drives
  dpio_edge u_irq1 (
    .clk(clk),
    .arst_n(arst_n),
    .enable(1'b1),
    .fall_sel(irq1_fall_sel),
    .level(port1_pin_in[dpio_pkg::P1_IRQ1_BIT]), // see [RQ11]
    .event_pulse(irq1_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helper: marks the first edge after reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_cyc_reg <= 1'b1;
    end else begin
      first_cyc_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_p0_write;
    @(posedge clk) disable iff (!arst_n)
    (sfr_wr && sfr_state2 && sfr_addr == dpio_pkg::OFS_PORT0_OUTPUT_LATCH)
    |=> (port0_output_latch_reg == $past(sfr_wdata));
  endproperty
  a_p0_write: assert property (p_p0_write) else $error("port0 latch missed write"); // see [RQ3]

  property p_hold;
    @(posedge clk) disable iff (!arst_n)
    !(sfr_wr && sfr_state2)
    |=> ($stable(port0_output_latch_reg) && $stable(port1_output_latch_reg));
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without a write"); // see [RQ1]

  property p_pin_sample;
    @(posedge clk) disable iff (!arst_n)
    (sfr_rd && !sfr_state2 && sfr_addr == dpio_pkg::OFS_PORT0_PIN_READ)
    |=> (sfr_rdata == $past(port0_pin_in));
  endproperty
  a_pin_sample: assert property (p_pin_sample) else $error("pin read not sampled"); // see [RQ2]

  property p_latch_read;
    @(posedge clk) disable iff (!arst_n)
    (sfr_rd && !sfr_state2 && !sfr_wr && sfr_addr == dpio_pkg::OFS_PORT0_OUTPUT_LATCH)
    |=> (sfr_rdata == port0_output_latch_reg);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read wrong"); // see [RQ7]

  property p_reset_vals;
    @(posedge clk) disable iff (!arst_n)
    first_cyc_reg |-> (port0_drive_type_reg == dpio_pkg::RST_PORT0_DRIVE_TYPE
                       && port1_direction_reg == dpio_pkg::RST_PORT1_DIRECTION
                       && port1_output_latch_reg == dpio_pkg::RST_PORT1_OUTPUT_LATCH
                       && port0_output_latch_reg == dpio_pkg::RST_PORT0_OUTPUT_LATCH);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value"); // see [RQ4]

  property p_p1_reset_input;
    @(posedge clk) disable iff (!arst_n)
    first_cyc_reg |-> (port1_pin_oe == '0);
  endproperty
  a_p1_reset_input: assert property (p_p1_reset_input) else $error("port1 not input"); // see [RQ8]

  property p_open_drain;
    @(posedge clk) disable iff (!arst_n)
    (port0_pin_oe == (port0_drive_type_reg | ~port0_output_latch_reg))
    && ((port0_pin_out & ~port0_drive_type_reg) == '0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("port0 driver wrong"); // see [RQ16]

  property p_push_pull;
    @(posedge clk) disable iff (!arst_n)
    ((port0_pin_out & port0_drive_type_reg)
     == (port0_output_latch_reg & port0_drive_type_reg));
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull data wrong"); // see [RQ5]

  property p_irq0_input;
    @(posedge clk) disable iff (!arst_n)
    irq0_pin_select |-> !port1_pin_oe[dpio_pkg::P1_IRQ0_BIT];
  endproperty
  a_irq0_input: assert property (p_irq0_input) else $error("irq0 pin driven"); // see [RQ15]

  property p_irq0_off;
    @(posedge clk) disable iff (!arst_n)
    !irq0_pin_select [*2] |-> !irq0_event;
  endproperty
  a_irq0_off: assert property (p_irq0_off) else $error("irq0 while port"); // see [RQ12]

  property p_dir_out;
    @(posedge clk) disable iff (!arst_n)
    (port1_pin_oe[dpio_pkg::P1_W-1:1] == port1_direction_reg[dpio_pkg::P1_W-1:1]);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("direction not applied"); // see [RQ8]

  // remaining registers, read hold, read-only address and irq1 edges
  property p_p1_write;
    @(posedge clk) disable iff (!arst_n)
    (sfr_wr && sfr_state2 && sfr_addr == dpio_pkg::OFS_PORT1_OUTPUT_LATCH)
    |=> ({1'b0, port1_output_latch_reg} == ($past(sfr_wdata) & {1'b0, {dpio_pkg::P1_W{1'b1}}}));
  endproperty
  a_p1_write: assert property (p_p1_write) else $error("port1 latch missed write"); // see [RQ3]

  property p_dir_write;
    @(posedge clk) disable iff (!arst_n)
    (sfr_wr && sfr_state2 && sfr_addr == dpio_pkg::OFS_PORT1_DIRECTION)
    |=> ({1'b0, port1_direction_reg} == ($past(sfr_wdata) & {1'b0, {dpio_pkg::P1_W{1'b1}}}));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction missed write"); // see [RQ8]

  property p_drive_write;
    @(posedge clk) disable iff (!arst_n)
    (sfr_wr && sfr_state2 && sfr_addr == dpio_pkg::OFS_PORT0_DRIVE_TYPE)
    |=> (port0_drive_type_reg == $past(sfr_wdata));
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("drive type missed write"); // see [RQ5]

  property p_rdata_hold;
    @(posedge clk) disable iff (!arst_n)
    !(sfr_rd && !sfr_state2)
    |=> $stable(sfr_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read"); // see [RQ2]

  property p_ro_write;
    @(posedge clk) disable iff (!arst_n)
    (sfr_wr && sfr_state2 && sfr_addr == dpio_pkg::OFS_PORT0_PIN_READ)
    |=> ($stable(port0_output_latch_reg) && $stable(port0_drive_type_reg)
         && $stable(port1_output_latch_reg) && $stable(port1_direction_reg));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write landed"); // see [RQ7]

  property p_irq1_edge;
    @(posedge clk) disable iff (!arst_n)
    (!first_cyc_reg && $changed(port1_pin_in[dpio_pkg::P1_IRQ1_BIT])
     && (port1_pin_in[dpio_pkg::P1_IRQ1_BIT] != irq1_fall_sel))
    |=> irq1_event;
  endproperty
  a_irq1_edge: assert property (p_irq1_edge) else $error("irq1 edge missed"); // see [RQ11]

endmodule : dpio_ports
`default_nettype wire

// ---- tb/dpio_board.sv ----
// board circuitry on the port pins: pull-ups and external sources
`timescale 1ns/100ps
`default_nettype none
module dpio_board (
  // pin drive from the port block
  input wire logic [dpio_pkg::P0_W-1:0] port0_pin_out,
  input wire logic [dpio_pkg::P0_W-1:0] port0_pin_oe,
  input wire logic [dpio_pkg::P1_W-1:0] port1_pin_out,
  input wire logic [dpio_pkg::P1_W-1:0] port1_pin_oe,
  // external sources
  input wire logic [dpio_pkg::P0_W-1:0] ext0_val,
  input wire logic [dpio_pkg::P0_W-1:0] ext0_drv,
  input wire logic [dpio_pkg::P1_W-1:0] ext1_val,
  // resolved pin levels
  output logic [dpio_pkg::P0_W-1:0] port0_pin_in,
  output logic [dpio_pkg::P1_W-1:0] port1_pin_in
);
  ////////////////////////////////////////////////////////////////////////////
  // port0 lines pulled up when nobody drives
  always_comb begin
    for (int i = 0; i < dpio_pkg::P0_W; i++) begin
      port0_pin_in[i] = port0_pin_oe[i] ? port0_pin_out[i] : (ext0_drv[i] ? ext0_val[i] : 1'b1);
    end
  end
  // port1 input lines always driven by the board
  assign port1_pin_in = (port1_pin_oe & port1_pin_out) | (~port1_pin_oe & ext1_val);
endmodule : dpio_board
`default_nettype wire

// ---- tb/test_dpio_ports.sv ----
// self-checking bench for the dual parallel port block
`timescale 1ns/100ps
`default_nettype none
module test_dpio_ports;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] sfr_addr = 6'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic sfr_wr = 1'b0;
  logic sfr_state2 = 1'b0;
  logic [7:0] sfr_rdata;
  logic irq0_pin_select = 1'b0;
  logic irq1_fall_sel = 1'b0;
  logic irq0_event;
  logic irq1_event;
  logic [7:0] port0_pin_in, port0_pin_out, port0_pin_oe;
  logic [6:0] port1_pin_in, port1_pin_out, port1_pin_oe;
  logic [7:0] ext0_val = 8'h00;
  logic [7:0] ext0_drv = 8'h00;
  logic [6:0] ext1_val = 7'h7f;
  logic [7:0] l0 = 8'hff, t0 = 8'h00, d;
  logic [6:0] l1 = 7'h00, r1 = 7'h00;
  logic [1:0] k;
  logic lv, pv = 1'b1;
  logic [5:0] ofs [4] = '{dpio_pkg::OFS_PORT0_OUTPUT_LATCH, dpio_pkg::OFS_PORT1_OUTPUT_LATCH,
                          dpio_pkg::OFS_PORT1_DIRECTION, dpio_pkg::OFS_PORT0_DRIVE_TYPE};
  int n_fail = 0, check_count = 0, seed = 21041, c0 = 0, c1 = 0, b0 = 0, b1 = 0, e1 = 0;

  dpio_ports u_dut (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_state2(sfr_state2), .sfr_rdata(sfr_rdata),
    .irq0_pin_select(irq0_pin_select), .irq1_fall_sel(irq1_fall_sel), .irq0_event(irq0_event),
    .irq1_event(irq1_event), .port0_pin_in(port0_pin_in), .port0_pin_out(port0_pin_out),
    .port0_pin_oe(port0_pin_oe), .port1_pin_in(port1_pin_in), .port1_pin_out(port1_pin_out),
    .port1_pin_oe(port1_pin_oe));
  dpio_board u_board (.port0_pin_out(port0_pin_out), .port0_pin_oe(port0_pin_oe),
    .port1_pin_out(port1_pin_out), .port1_pin_oe(port1_pin_oe), .ext0_val(ext0_val),
    .ext0_drv(ext0_drv), .ext1_val(ext1_val), .port0_pin_in(port0_pin_in),
    .port1_pin_in(port1_pin_in));

  ////////////////////////////////////////////////////////////////////////////
  // clock and interrupt pulse counters
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (irq0_event === 1'b1) c0++;
    if (irq1_event === 1'b1) c1++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // expectations
  function automatic logic [7:0] p1oe(input logic [6:0] dr, input logic sel);
    return {1'b0, sel ? (dr & 7'h7e) : dr};
  endfunction : p1oe
  function automatic logic [7:0] regval(input logic [1:0] i);
    case (i)
      2'd0: return l0;
      2'd1: return {1'b0, l1};
      2'd2: return {1'b0, r1};
      default: return t0;
    endcase
  endfunction : regval
  // expected irq1 level from latch and direction; counts the selected edge
  task automatic track();
    lv = r1[1] ? l1[1] : ext1_val[1];
    if (lv != pv && lv != irq1_fall_sel) e1++;
    pv = lv;
  endtask : track

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycles, pulse counting
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic st2);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_state2 = st2;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_state2 = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic st2, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    sfr_state2 = st2;
    @(negedge clk);
    sfr_rd = 1'b0;
    sfr_state2 = 1'b0;
    chk("read data", exp, sfr_rdata);
  endtask : rd
  task automatic pulses(input int e0, input int e1);
    repeat (3) @(negedge clk);
    chk("irq0 pulses", 8'(e0), 8'(c0 - b0));
    chk("irq1 pulses", 8'(e1), 8'(c1 - b1));
    b0 = c0;
    b1 = c1;
  endtask : pulses
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #500000;
    n_fail++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    chk("p0 oe", 8'h00, port0_pin_oe);
    chk("p1 oe", 8'h00, {1'b0, port1_pin_oe});
    rd(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, 1'b0, 8'hff);
    rd(dpio_pkg::OFS_PORT0_DRIVE_TYPE, 1'b0, 8'h00);
    rd(dpio_pkg::OFS_PORT1_OUTPUT_LATCH, 1'b0, 8'h00);
    rd(dpio_pkg::OFS_PORT1_DIRECTION, 1'b0, 8'h00);
    rd(dpio_pkg::OFS_PORT0_PIN_READ, 1'b0, 8'hff);
    $display("reset test done");
    // random register traffic with pin checks; irq1 rising edges tracked
    for (int i = 0; i < 20; i++) begin
      k = 2'($random(seed));
      d = 8'($random(seed)); // whole bytes, no read-modify-write
      wr(ofs[k], d, 1'b1);
      case (k)
        2'd0: l0 = d;
        2'd1: l1 = d[6:0];
        2'd2: r1 = d[6:0];
        default: t0 = d;
      endcase
      track();
      chk("p0 out", t0 & l0, port0_pin_out);
      chk("p0 oe", t0 | ~l0, port0_pin_oe);
      chk("p1 out", {1'b0, l1}, {1'b0, port1_pin_out});
      chk("p1 oe", p1oe(r1, 1'b0), {1'b0, port1_pin_oe});
      rd(ofs[k], 1'b0, regval(k));
    end
    // refused accesses; a known nonzero latch keeps a wrongly taken read visible
    wr(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, 8'h3c, 1'b1);
    l0 = 8'h3c;
    wr(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, ~l0, 1'b0);
    rd(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, 1'b0, l0);
    rd(6'h02, 1'b0, dpio_pkg::READ_UNMAPPED); // not reserved, not decoded here
    rd(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, 1'b1, dpio_pkg::READ_UNMAPPED);
    $display("register test done");
    // pin readback: open-drain released, then push-pull
    wr(dpio_pkg::OFS_PORT0_DRIVE_TYPE, 8'h00, 1'b1);
    wr(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, 8'hff, 1'b1);
    ext0_drv = 8'hff;
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      ext0_val = d;
      rd(dpio_pkg::OFS_PORT0_PIN_READ, 1'b0, d);
      rd(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, 1'b0, 8'hff);
    end
    ext0_drv = 8'h00;
    wr(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, 8'h5a, 1'b1);
    rd(dpio_pkg::OFS_PORT0_PIN_READ, 1'b0, 8'h5a); // zeros sunk, ones pulled up
    wr(dpio_pkg::OFS_PORT0_DRIVE_TYPE, 8'hff, 1'b1);
    wr(dpio_pkg::OFS_PORT0_PIN_READ, 8'h00, 1'b1);
    rd(dpio_pkg::OFS_PORT0_PIN_READ, 1'b0, 8'h5a);
    $display("pin test done");
    // interrupt pins on the seven-bit port
    wr(dpio_pkg::OFS_PORT1_OUTPUT_LATCH, 8'h02, 1'b1);
    l1 = 7'h02;
    track();
    wr(dpio_pkg::OFS_PORT1_DIRECTION, 8'h02, 1'b1);
    r1 = 7'h02;
    track();
    pulses(0, e1);
    wr(dpio_pkg::OFS_PORT1_OUTPUT_LATCH, 8'h00, 1'b1);
    pulses(0, 0);
    wr(dpio_pkg::OFS_PORT1_OUTPUT_LATCH, 8'h02, 1'b1);
    pulses(0, 1);
    irq1_fall_sel = 1'b1;
    wr(dpio_pkg::OFS_PORT1_OUTPUT_LATCH, 8'h00, 1'b1);
    pulses(0, 1);
    ext1_val = 7'h7e;
    pulses(0, 0);
    ext1_val = 7'h7f;
    pulses(0, 0);
    irq0_pin_select = 1'b1;
    wr(dpio_pkg::OFS_PORT1_DIRECTION, 8'h03, 1'b1);
    chk("p1 oe", p1oe(7'h03, 1'b1), {1'b0, port1_pin_oe});
    ext1_val = 7'h7e;
    pulses(1, 0);
    irq0_pin_select = 1'b0;
    @(negedge clk);
    chk("p1 oe", p1oe(7'h03, 1'b0), {1'b0, port1_pin_oe});
    $display("interrupt test done");
    // second reset in mid-run
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk("p1 oe", 8'h00, {1'b0, port1_pin_oe});
    rd(dpio_pkg::OFS_PORT0_OUTPUT_LATCH, 1'b0, 8'hff);
    rd(dpio_pkg::OFS_PORT1_DIRECTION, 1'b0, 8'h00);
    $display("second reset test done");
    final_report();
  end
endmodule : test_dpio_ports
`default_nettype wire
